// ===== hdl/hppc_ctrl.sv
// Purpose: Downstream port speed, power switching and charging control for a four-port hub
// Assumes: One 40 MHz clock; host requests and link state are on the core clock
// Notes:   Over-current pins are asynchronous and pass a three-stage synchroniser
//
// Functional notes
// - HS or FS upstream disables downstream SuperSpeed
// - FS upstream also disables downstream high speed
// - Individual mode follows per-port power requests
// - Individual over-current removes only that port
// - Ganged power on when any port needs
// - Ganged power stays until all allow removal
// - Ganged over-current removes all port power
// - Connected upstream: charging ports run CDP handshake
// - Unconnected upstream: charging ports may act DCP
// - Three divider modes when unconnected or unconfigured
// - Auto sweep starts divider three, ends DCP
// - Billboard sits on highest USB 2.0 port
// - Billboard reports exactly one alternate mode
// - HID port speed matches upstream HS or FS
// - Each port configurable USB 2.0 only
// - Four external ports plus two internal ports
// - Reset returns all state to defaults
`timescale 1ns/1ps
module hppc_ctrl #(
  parameter int unsigned AUTO_STEP_CYC = hppc_pkg::AUTO_STEP_CYC
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_rstn,
  input  wire logic [1:0]                     i_up_speed,
  input  wire logic                           i_up_connected,
  input  wire logic                           i_up_configured,
  input  wire logic                           i_cfg_ganged,
  input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_cfg_usb2_only,
  input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_cfg_chg_en,
  input  wire logic [2:0]                     i_cfg_chg_sel,
  input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_port_pwr_req,
  input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_port_pwr_hold,
  input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_ovc_n,
  input  wire logic                           i_bb_alt_active,
  output logic      [hppc_pkg::NUM_PORTS-1:0] o_port_pwr_en,
  output logic      [hppc_pkg::NUM_PORTS-1:0] o_port_ovc,
  output logic      [hppc_pkg::NUM_PORTS-1:0] o_port_ss_en,
  output logic      [hppc_pkg::NUM_PORTS-1:0] o_port_hs_en,
  output logic      [11:0]                    o_port_chg_mode,
  output logic                                o_hid_port_hs,
  output logic                                o_hid_port_en,
  output logic      [2:0]                     o_bb_port_num,
  output logic                                o_bb_port_en,
  output logic      [hppc_pkg::NUM_ALT_MODES-1:0] o_bb_alt_status,
  output logic                                o_auto_busy
);

  localparam int unsigned NP      = hppc_pkg::NUM_PORTS;
  // Ports 1..4 external, 5 HID, 6 billboard as highest USB 2.0 port
  localparam int unsigned BB_PORT = NP + hppc_pkg::NUM_INT_PORTS;

  // ---------------------------------------------------------------
  // Over-current synchronisation
  // ---------------------------------------------------------------
  logic [NP-1:0] ovc_raw;
  logic [NP-1:0] ovc;

  // Invert before the flops: their reset zero then means no fault
  assign ovc_raw = ~i_ovc_n;

  // One synchroniser per port, so a bouncing pin cannot stall the others
  // Pin to power switch takes about five clocks
  for (genvar p = 0; p < NP; p++) begin : g_ovc_sync
    hppc_sync #(
      .W (1)
    ) u_ovc_sync (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_async (ovc_raw[p]),
      .o_sync  (ovc[p])
    );
  end

  // ---------------------------------------------------------------
  // Speed gating
  // ---------------------------------------------------------------
  logic up_ss;
  logic up_hs_or_ss;
  logic up_present;
  logic [NP-1:0] ss_en_d;
  logic [NP-1:0] hs_en_d;
  logic [NP-1:0] ss_en_q;
  logic [NP-1:0] hs_en_q;
  logic          hid_hs_q;
  logic          hid_en_q;

  assign up_ss       = (i_up_speed == hppc_pkg::HPPC_SPD_SS);
  assign up_hs_or_ss = up_ss || (i_up_speed == hppc_pkg::HPPC_SPD_HS);
  // HID and billboard ports only come up once upstream has a speed
  assign up_present  = (i_up_speed != hppc_pkg::HPPC_SPD_NONE);
  assign ss_en_d     = {NP{up_ss}} & ~i_cfg_usb2_only;
  assign hs_en_d     = {NP{up_hs_or_ss}};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ss_en_q  <= '0;
      hs_en_q  <= '0;
      hid_hs_q <= 1'b0;
      hid_en_q <= 1'b0;
    end else begin
      ss_en_q  <= ss_en_d;
      hs_en_q  <= hs_en_d;
      hid_hs_q <= up_hs_or_ss;
      hid_en_q <= up_present;
    end
  end

  // ---------------------------------------------------------------
  // Power switching
  // ---------------------------------------------------------------
  logic          any_ovc;
  logic          gang_on_d;
  logic          gang_q;
  logic [NP-1:0] ind_pwr_d;
  logic [NP-1:0] pwr_q;
  logic [NP-1:0] pwr_d;
  logic [NP-1:0] ovc_q;
  logic [NP-1:0] ovc_d;

  assign any_ovc   = |ovc;
  // Stays on while any port still holds power, even with no request
  assign gang_on_d = !any_ovc && ((|i_port_pwr_req) || (gang_q && (|i_port_pwr_hold)));
  assign ind_pwr_d = i_port_pwr_req & ~ovc;
  // No fault latch: an individual port repowers once its flag clears
  assign pwr_d     = i_cfg_ganged ? {NP{gang_on_d}} : ind_pwr_d;
  assign ovc_d     = i_cfg_ganged ? {NP{any_ovc}} : ovc;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gang_q <= 1'b0;
      pwr_q  <= hppc_pkg::PWR_RST;
      ovc_q  <= '0;
    end else begin
      gang_q <= gang_on_d;
      pwr_q  <= pwr_d;
      ovc_q  <= ovc_d;
    end
  end

  // ---------------------------------------------------------------
  // Automatic charging sweep
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HPPC_AUTO_IDLE,
    HPPC_AUTO_DIV3,
    HPPC_AUTO_DIV2,
    HPPC_AUTO_DIV1,
    HPPC_AUTO_DCP
  } hppc_auto_t;

  hppc_auto_t            auto_q;
  hppc_auto_t            auto_d;
  logic [hppc_pkg::AUTO_CNT_W-1:0] cnt_q;
  logic [hppc_pkg::AUTO_CNT_W-1:0] cnt_d;
  logic                  auto_sel;
  logic                  cnt_done;
  logic                  auto_run;
  logic                  auto_busy;
  logic [hppc_pkg::AUTO_CNT_W-1:0] cnt_inc;

  assign auto_sel = (i_cfg_chg_sel == hppc_pkg::CFG_CHG_AUTO);
  // Sweep restarts at divider three after every upstream disconnect
  assign auto_run = auto_sel && !i_up_connected;
  assign cnt_done = (cnt_q == hppc_pkg::AUTO_CNT_W'(AUTO_STEP_CYC - 1));
  assign cnt_inc  = cnt_q + hppc_pkg::AUTO_CNT_W'(1);
  assign auto_busy = (auto_q != HPPC_AUTO_IDLE) && (auto_q != HPPC_AUTO_DCP);

  always_comb begin
    auto_d = auto_q;
    cnt_d  = cnt_done ? hppc_pkg::CNT_RST : cnt_inc;
    if (!auto_run) begin
      auto_d = HPPC_AUTO_IDLE;
      cnt_d  = hppc_pkg::CNT_RST;
    end else begin
      case (auto_q)
        HPPC_AUTO_IDLE: begin
          auto_d = HPPC_AUTO_DIV3;
          cnt_d  = hppc_pkg::CNT_RST;
        end
        HPPC_AUTO_DIV3: if (cnt_done) auto_d = HPPC_AUTO_DIV2;
        HPPC_AUTO_DIV2: if (cnt_done) auto_d = HPPC_AUTO_DIV1;
        HPPC_AUTO_DIV1: if (cnt_done) auto_d = HPPC_AUTO_DCP;
        HPPC_AUTO_DCP: begin
          // Final mode holds until upstream connects
          cnt_d = hppc_pkg::CNT_RST;
        end
        default: auto_d = HPPC_AUTO_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      auto_q <= HPPC_AUTO_IDLE;
      cnt_q  <= hppc_pkg::CNT_RST;
    end else begin
      auto_q <= auto_d;
      cnt_q  <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Charging mode select
  // ---------------------------------------------------------------
  hppc_pkg::hppc_chg_t chg_mode;
  hppc_pkg::hppc_chg_t auto_mode;
  logic                div_ok;
  logic [11:0]         chg_q;
  logic [11:0]         chg_d;

  // Divider modes fall back to the handshake once configured
  assign div_ok = !i_up_connected || !i_up_configured;

  always_comb begin
    case (auto_q)
      HPPC_AUTO_DIV3: auto_mode = hppc_pkg::HPPC_CHG_DIV3;
      HPPC_AUTO_DIV2: auto_mode = hppc_pkg::HPPC_CHG_DIV2;
      HPPC_AUTO_DIV1: auto_mode = hppc_pkg::HPPC_CHG_DIV1;
      HPPC_AUTO_DCP:  auto_mode = hppc_pkg::HPPC_CHG_DCP;
      default:        auto_mode = hppc_pkg::HPPC_CHG_OFF;
    endcase
  end

  always_comb begin
    chg_mode = hppc_pkg::HPPC_CHG_OFF;
    case (i_cfg_chg_sel)
      hppc_pkg::CFG_CHG_BC: begin
        if (i_up_connected) chg_mode = hppc_pkg::HPPC_CHG_CDP;
        else chg_mode = hppc_pkg::HPPC_CHG_DCP;
      end
      hppc_pkg::CFG_CHG_DIV1: begin
        if (div_ok) chg_mode = hppc_pkg::HPPC_CHG_DIV1;
        else chg_mode = hppc_pkg::HPPC_CHG_CDP;
      end
      hppc_pkg::CFG_CHG_DIV2: begin
        if (div_ok) chg_mode = hppc_pkg::HPPC_CHG_DIV2;
        else chg_mode = hppc_pkg::HPPC_CHG_CDP;
      end
      hppc_pkg::CFG_CHG_DIV3: begin
        if (div_ok) chg_mode = hppc_pkg::HPPC_CHG_DIV3;
        else chg_mode = hppc_pkg::HPPC_CHG_CDP;
      end
      hppc_pkg::CFG_CHG_AUTO: begin
        if (i_up_connected) chg_mode = hppc_pkg::HPPC_CHG_CDP;
        else chg_mode = auto_mode;
      end
      default: chg_mode = hppc_pkg::HPPC_CHG_OFF;
    endcase
  end

  // Disabled ports report off; all enabled ports share one mode
  for (genvar p = 0; p < NP; p++) begin : g_chg
    assign chg_d[3*p +: 3] = i_cfg_chg_en[p] ? chg_mode : hppc_pkg::HPPC_CHG_OFF;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chg_q <= '0;
    end else begin
      chg_q <= chg_d;
    end
  end

  // ---------------------------------------------------------------
  // Internal ports and billboard
  // ---------------------------------------------------------------
  logic       bb_en_q;
  logic       bb_alt_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bb_en_q  <= 1'b0;
      bb_alt_q <= 1'b0;
    end else begin
      bb_en_q  <= up_present;
      // One status bit: only a single alternate mode exists
      bb_alt_q <= i_bb_alt_active;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_bb_port_num   = 3'(BB_PORT);
  assign o_port_pwr_en   = pwr_q;
  assign o_port_ovc      = ovc_q;
  assign o_port_ss_en    = ss_en_q;
  assign o_port_hs_en    = hs_en_q;
  assign o_port_chg_mode = chg_q;
  assign o_hid_port_hs   = hid_hs_q;
  assign o_hid_port_en   = hid_en_q;
  assign o_bb_port_en    = bb_en_q;
  assign o_bb_alt_status = bb_alt_q;
  assign o_auto_busy     = auto_busy;

endmodule : hppc_ctrl

// ===== shared/hppc_pkg.sv
// Purpose: Shared constants and types for the hub port power and charge control block
// Assumes: Single 40 MHz core clock, four external downstream ports
// Notes:   Speeds, charge modes and timing counts live here
package hppc_pkg;

  // ---------------------------------------------------------------
  // Port counts
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS     = 4;
  localparam int unsigned NUM_INT_PORTS = 2;
  localparam int unsigned NUM_ALT_MODES = 1;

  // ---------------------------------------------------------------
  // Upstream link speed encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HPPC_SPD_NONE = 2'h0,
    HPPC_SPD_FS   = 2'h1,
    HPPC_SPD_HS   = 2'h2,
    HPPC_SPD_SS   = 2'h3
  } hppc_speed_t;

  // ---------------------------------------------------------------
  // Charging behaviour per port
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HPPC_CHG_OFF  = 3'h0,
    HPPC_CHG_CDP  = 3'h1,
    HPPC_CHG_DCP  = 3'h2,
    HPPC_CHG_DIV1 = 3'h3,
    HPPC_CHG_DIV2 = 3'h4,
    HPPC_CHG_DIV3 = 3'h5
  } hppc_chg_t;

  // Charge configuration select
  localparam logic [2:0] CFG_CHG_NONE = 3'h0;
  localparam logic [2:0] CFG_CHG_BC   = 3'h1;
  localparam logic [2:0] CFG_CHG_DIV1 = 3'h2;
  localparam logic [2:0] CFG_CHG_DIV2 = 3'h3;
  localparam logic [2:0] CFG_CHG_DIV3 = 3'h4;
  localparam logic [2:0] CFG_CHG_AUTO = 3'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned AUTO_STEP_MS   = 1;
  localparam int unsigned AUTO_STEP_CYC  = (AUTO_STEP_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned AUTO_CNT_W     = 16;

  // Reset values
  localparam logic [NUM_PORTS-1:0] PWR_RST  = 4'h0;
  localparam logic [AUTO_CNT_W-1:0] CNT_RST = 16'h0000;

endpackage : hppc_pkg

// ===== hdl/hppc_sync.sv
// Purpose: Three-stage synchroniser with second/third stage agreement
// Assumes: Input is asynchronous to i_clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module hppc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  assign out_d  = (s2_q == s3_q) ? s3_q : out_q;
  assign o_sync = out_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

endmodule : hppc_sync

// ===== sim/hppc_sw_model.sv
// Purpose: Downstream power switch model for four ports
// Assumes: Fault requests come from the bench
// Notes:   Fault flag is active low
`timescale 1ns/1ps
module hppc_sw_model (
  input  wire logic [3:0] i_pwr_en,
  input  wire logic [3:0] i_fault,
  output logic      [3:0] o_ovc_n,
  output logic      [3:0] o_vbus
);
  // Flag held while faulted, even once switched off, so no retry chatter
  assign o_ovc_n = ~i_fault;
  assign o_vbus  = i_pwr_en & ~i_fault;
endmodule : hppc_sw_model

// ===== sim/hppc_ctrl_asserts.sv
// Purpose: Port-level checks for hppc_ctrl
// Assumes: Single clock, async active-low reset
// Notes:   Bound to every hppc_ctrl instance
`timescale 1ns/1ps
module hppc_ctrl_asserts (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [1:0]  i_up_speed,
  input wire logic        i_up_connected,
  input wire logic        i_cfg_ganged,
  input wire logic [3:0]  i_cfg_usb2_only,
  input wire logic [3:0]  i_cfg_chg_en,
  input wire logic [2:0]  i_cfg_chg_sel,
  input wire logic [3:0]  i_port_pwr_req,
  input wire logic [3:0]  i_port_pwr_hold,
  input wire logic [3:0]  i_ovc_n,
  input wire logic        i_bb_alt_active,
  input wire logic [3:0]  o_port_pwr_en,
  input wire logic [3:0]  o_port_ovc,
  input wire logic [3:0]  o_port_ss_en,
  input wire logic [3:0]  o_port_hs_en,
  input wire logic [11:0] o_port_chg_mode,
  input wire logic        o_hid_port_hs,
  input wire logic        o_hid_port_en,
  input wire logic [2:0]  o_bb_port_num,
  input wire logic        o_bb_alt_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ---------------------------------------------------------------
  // Sequences and properties
  // ---------------------------------------------------------------
  sequence s_ovc_low;
    !i_ovc_n[0] [*7];
  endsequence
  sequence s_gang_req;
    i_cfg_ganged && (|i_port_pwr_req);
  endsequence
  property p_ss_off;
    (i_up_speed == 2'h1 || i_up_speed == 2'h2) |=> o_port_ss_en == 4'h0;
  endproperty
  property p_hs_off;
    i_up_speed == 2'h1 |=> o_port_hs_en == 4'h0 && o_hid_port_en && !o_hid_port_hs;
  endproperty
  property p_usb2;
    1'b1 |=> (o_port_ss_en & $past(i_cfg_usb2_only)) == 4'h0;
  endproperty
  property p_indiv;
    !i_cfg_ganged |=> o_port_pwr_en == ($past(i_port_pwr_req) & ~o_port_ovc);
  endproperty
  property p_gang_on;
    s_gang_req |=> o_port_pwr_en == 4'hf || o_port_ovc != 4'h0;
  endproperty
  property p_gang_keep;
    $past(i_cfg_ganged) && i_cfg_ganged && o_port_pwr_en == 4'hf && (|i_port_pwr_hold)
      |=> o_port_pwr_en == 4'hf || o_port_ovc != 4'h0;
  endproperty
  property p_gang_ovc;
    $past(i_cfg_ganged) && i_cfg_ganged && o_port_ovc != 4'h0
      |-> o_port_pwr_en == 4'h0 && o_port_ovc == 4'hf;
  endproperty
  property p_ovc_sync;
    s_ovc_low |-> o_port_ovc[0] && !o_port_pwr_en[0];
  endproperty
  property p_cdp;
    i_cfg_chg_en[0] && i_cfg_chg_sel == hppc_pkg::CFG_CHG_BC && i_up_connected
      |=> o_port_chg_mode[2:0] == 3'h1;
  endproperty
  property p_dcp;
    i_cfg_chg_en[0] && i_cfg_chg_sel == hppc_pkg::CFG_CHG_BC && !i_up_connected
      |=> o_port_chg_mode[2:0] == 3'h2;
  endproperty
  property p_rst;
    disable iff (1'b0) !i_rstn |-> o_port_pwr_en == 4'h0 && o_port_chg_mode == 12'h000;
  endproperty
  property p_bb;
    1'b1 |=> o_bb_port_num == 3'h6 && o_bb_alt_status == $past(i_bb_alt_active);
  endproperty
  a_ss_off:    assert property (p_ss_off) else $error("ss enabled on slow upstream");
  a_hs_off:    assert property (p_hs_off) else $error("hs enabled on fs upstream");
  a_usb2:      assert property (p_usb2) else $error("ss on usb2-only port");
  a_indiv:     assert property (p_indiv) else $error("individual power wrong");
  a_gang_on:   assert property (p_gang_on) else $error("ganged power not on");
  a_gang_keep: assert property (p_gang_keep) else $error("ganged power dropped");
  a_gang_ovc:  assert property (p_gang_ovc) else $error("ganged fault kept power");
  a_ovc_sync:  assert property (p_ovc_sync) else $error("fault not acted on");
  a_cdp:       assert property (p_cdp) else $error("no cdp when connected");
  a_dcp:       assert property (p_dcp) else $error("no dcp when unconnected");
  a_rst:       assert property (p_rst) else $error("outputs active in reset");
  a_bb:        assert property (p_bb) else $error("billboard port wrong");
endmodule : hppc_ctrl_asserts

bind hppc_ctrl hppc_ctrl_asserts hppc_ctrl_asserts_i (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_up_speed(i_up_speed), .i_up_connected(i_up_connected),
  .i_cfg_ganged(i_cfg_ganged), .i_cfg_usb2_only(i_cfg_usb2_only),
  .i_cfg_chg_en(i_cfg_chg_en), .i_cfg_chg_sel(i_cfg_chg_sel),
  .i_port_pwr_req(i_port_pwr_req), .i_port_pwr_hold(i_port_pwr_hold), .i_ovc_n(i_ovc_n),
  .i_bb_alt_active(i_bb_alt_active), .o_port_pwr_en(o_port_pwr_en), .o_port_ovc(o_port_ovc),
  .o_port_ss_en(o_port_ss_en), .o_port_hs_en(o_port_hs_en), .o_port_chg_mode(o_port_chg_mode),
  .o_hid_port_hs(o_hid_port_hs), .o_hid_port_en(o_hid_port_en),
  .o_bb_port_num(o_bb_port_num), .o_bb_alt_status(o_bb_alt_status)
);

// ===== sim/tb.sv
// Purpose: Self-checking bench for hppc_ctrl
// Assumes: Auto sweep step shortened to 4 cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  logic        clk, rstn, conn, cfgd, gcfg, alt, gst, hid_hs, hid_en, bb_en, bb_alt, busy;
  logic [1:0]  spd;
  logic [2:0]  sel, bb_num;
  logic [3:0]  u2, cen, req, hold, fault, ovc_n, vbus, pwr, ovc, ss, hs;
  logic [11:0] chg;
  logic [14:0] sweep;
  logic [2:0]  q[$];
  int          mismatches, tests_run, cyc, seed;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  hppc_ctrl #(.AUTO_STEP_CYC(4)) hppc_ctrl_i (
    .i_clk(clk), .i_rstn(rstn), .i_up_speed(spd), .i_up_connected(conn),
    .i_up_configured(cfgd), .i_cfg_ganged(gcfg), .i_cfg_usb2_only(u2),
    .i_cfg_chg_en(cen), .i_cfg_chg_sel(sel), .i_port_pwr_req(req),
    .i_port_pwr_hold(hold), .i_ovc_n(ovc_n), .i_bb_alt_active(alt),
    .o_port_pwr_en(pwr), .o_port_ovc(ovc), .o_port_ss_en(ss), .o_port_hs_en(hs),
    .o_port_chg_mode(chg), .o_hid_port_hs(hid_hs), .o_hid_port_en(hid_en),
    .o_bb_port_num(bb_num), .o_bb_port_en(bb_en), .o_bb_alt_status(bb_alt),
    .o_auto_busy(busy)
  );
  hppc_sw_model hppc_sw_model_i (.i_pwr_en(pwr), .i_fault(fault), .o_ovc_n(ovc_n),
    .o_vbus(vbus));

  task automatic conclude;
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // Model evaluated once inputs have settled past the fault synchroniser
  task automatic settle_check;
    logic [2:0]  m;
    logic [11:0] ec;
    repeat (8) @(negedge clk);
    gst = gcfg && !(|fault) && ((|req) || (gst && (|hold)));
    case (sel)
      3'h1:             m = conn ? 3'h1 : 3'h2;
      3'h2, 3'h3, 3'h4: m = (conn && cfgd) ? 3'h1 : sel + 3'h1;
      default:          m = 3'h0;
    endcase
    for (int i = 0; i < 4; i++) ec[3*i +: 3] = cen[i] ? m : 3'h0;
    `CHK("pwr", gcfg ? {4{gst}} : req & ~fault, pwr)
    `CHK("ovc", gcfg ? {4{|fault}} : fault, ovc)
    `CHK("ss", (spd == 2'h3) ? ~u2 : 4'h0, ss)
    `CHK("hs", (spd == 2'h1) ? 4'h0 : 4'hf, hs)
    `CHK("chg", ec, chg)
    `CHK("hid", {1'b1, spd != 2'h1}, {hid_en, hid_hs})
    `CHK("bb", {3'h6, alt, spd != 2'h0}, {bb_num, bb_alt, bb_en})
    `CHK("vbus", (gcfg ? {4{gst}} : req) & ~fault, vbus)
  endtask : settle_check

  // Hold only offered once ganged, faults only in individual mode
  task automatic randomize_inputs;
    logic pg;
    @(negedge clk);
    pg    = gcfg;
    gcfg  = 1'($random(seed));
    spd   = 2'(1 + {$random(seed)} % 3);
    sel   = 3'({$random(seed)} % 5);
    {conn, cfgd, alt} = 3'($random(seed));
    {u2, cen, req}    = 12'($random(seed));
    hold  = (pg && gcfg) ? 4'($random(seed)) : 4'h0;
    fault = gcfg ? 4'h0 : 4'($random(seed));
    settle_check();
  endtask : randomize_inputs

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    seed = 39795;
    {rstn, conn, cfgd, gcfg, alt, gst} = 6'h00;
    {spd, sel, u2, cen, req, hold, fault} = 23'h0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (60) randomize_inputs();
    gcfg = 1'b1;
    hold = 4'h0;
    req = 4'hf;
    fault = 4'h4;
    settle_check();
    fault = 4'h0;
    settle_check();
    req = 4'h0;
    hold = 4'h2;
    settle_check();
    hold = 4'h0;
    settle_check();
    {sel, conn, gcfg, cen, req} = {3'h0, 1'b0, 1'b0, 4'h1, 4'hf};
    repeat (4) @(negedge clk);
    sel = 3'h5;
    repeat (40) begin
      @(negedge clk);
      if (chg[2:0] == 3'h4) `CHK("busy", 1'b1, busy)
      if (q.size() == 0 || q[$] !== chg[2:0]) q.push_back(chg[2:0]);
    end
    sweep = {q[0], q[1], q[2], q[3], q[4]};
    `CHK("sweep", 15'h0b1a, sweep)
    `CHK("idle", 1'b0, busy)
    rstn = 1'b0;
    #1;
    `CHK("rst_pwr", 4'h0, pwr)
    `CHK("rst_chg", 12'h000, chg)
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK("rel_ovc", 4'h0, ovc)
    `CHK("rel_pwr", 4'hf, pwr)
    randomize_inputs();
    conclude();
  end
endmodule : tb
